// ### gpio_indicator.sv
// Notes on behaviour
// - Output pads drive both high and low
// - Indicator pin is inverse of lamp
// - Lamp dark when off, lit in call
// - Searching: 1 s period, 0.5 s lit
// - Registered: 3 s period, 0.3 s lit
// - Low inhibit pad blocks the transmitter
// - Monitor rises with transmit, falls after
// - Call mode: 300 ms lead, 500 ms hang
// - Burst mode: monitor follows each burst
// - Alarm output high until clear command
// - Alarm output high during reset
// - Buzzer pad carries tone square wave
// - Analog input sampled as 10-bit word
// - Read command returns millivolts
// - Pads start as inputs with pull-down, the alarm pad only after reset
`timescale 1ns/1ps
`include "gpio_map.svh"

module gpio_indicator #(
   parameter int NUM_PADS = 10,
   parameter int FAST_PERIOD_CYC = `FAST_PERIOD_MS * `CLK_KHZ,
   parameter int FAST_ON_CYC = `FAST_ON_MS * `CLK_KHZ,
   parameter int SLOW_PERIOD_CYC = `SLOW_PERIOD_MS * `CLK_KHZ,
   parameter int SLOW_ON_CYC = `SLOW_ON_MS * `CLK_KHZ,
   parameter int LEAD_CYC = `LEAD_MS * `CLK_KHZ,
   parameter int HANG_CYC = `HANG_MS * `CLK_KHZ
) (
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Pads
   input wire logic [NUM_PADS-1:0] pad_in,
   output logic [NUM_PADS-1:0] pad_out,
   output logic [NUM_PADS-1:0] pad_oe,
   output logic [NUM_PADS-1:0] pad_pd,
   // Radio and alarm side
   input wire logic call_active,
   input wire logic tx_burst,
   input wire logic alarm_fire,
   input wire logic [`ADC_BITS-1:0] adc_code,
   output logic tx_permit,
   output logic irq
);

   // Counter width covers the longest blink period
   localparam int CW = 27;

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wr_ctrl = wr && (addr == `ADDR_CTRL);
   wire wr_func = wr && (addr == `ADDR_FUNC);
   wire wr_drive = wr && (addr == `ADDR_DRIVE);
   wire wr_pull = wr && (addr == `ADDR_PULL);
   wire wr_alarm_clr = wr && (addr == `ADDR_ALARM_CLR);
   wire wr_tone = wr && (addr == `ADDR_TONE);
   wire wr_adc_cmd = wr && (addr == `ADDR_ADC_CMD);
   wire wr_irq_clr = wr && (addr == `ADDR_IRQ_CLR);
   wire wr_irq_en = wr && (addr == `ADDR_IRQ_EN);

   // Software-held state
   logic [2:0] ctrl_reg; // Lamp state and monitor mode
   logic [2*NUM_PADS-1:0] func_reg; // Two select bits per pad
   logic [NUM_PADS-1:0] drive_reg; // Plain output levels
   logic [NUM_PADS-1:0] pull_reg; // Pull-down enables
   logic [15:0] tone_reg; // Buzzer half period in cycles
   logic [10:0] adc_mv_reg; // Last converted result in mV
   logic [`IRQ_BITS-1:0] irq_stat_reg; // Sticky events
   logic [`IRQ_BITS-1:0] irq_en_reg; // Event enables

   // Views of the control register
   gpio_pkg::net_state_t net_state;
   gpio_pkg::mon_mode_t mon_mode;
   assign net_state = gpio_pkg::net_state_t'(ctrl_reg[1:0]);
   assign mon_mode = gpio_pkg::mon_mode_t'(ctrl_reg[`CTRL_MODE_BIT]);

   // Which alternate functions are selected
   wire inhibit_sel = func_reg[2*`INHIBIT_PAD +: 2] ==
                      2'(gpio_pkg::PAD_ALTERNATE);
   wire tone_sel = func_reg[2*`TONE_PAD +: 2] ==
                   2'(gpio_pkg::PAD_ALTERNATE);

   ////////////////////////////////////////////////////////////////////////
   // Lamp pattern: a free counter that restarts when the state changes
   logic [CW-1:0] blink_reg;
   logic [1:0] state_seen_reg;
   wire slow_blink = (net_state == gpio_pkg::NET_REGISTERED);
   wire [CW-1:0] period_cyc = slow_blink ? CW'(SLOW_PERIOD_CYC)
                                         : CW'(FAST_PERIOD_CYC);
   wire [CW-1:0] on_cyc = slow_blink ? CW'(SLOW_ON_CYC)
                                     : CW'(FAST_ON_CYC);
   wire state_moved = (state_seen_reg != ctrl_reg[1:0]);
   wire blink_wrap = (blink_reg >= period_cyc - 1'b1);
   wire [CW-1:0] blink_next = (state_moved || blink_wrap) ? '0
                                                          : blink_reg + 1'b1;
   // Each period opens with its lit part
   wire blink_lit = (blink_reg < on_cyc);
   logic lamp_on;

   // Lamp level for each network state
   always_comb begin
      case (net_state)
         gpio_pkg::NET_OFF: lamp_on = 1'b0;
         gpio_pkg::NET_CALL: lamp_on = 1'b1;
         gpio_pkg::NET_SEARCH: lamp_on = blink_lit;
         gpio_pkg::NET_REGISTERED: lamp_on = blink_lit;
         default: lamp_on = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit monitor: lead-in before the first burst, hang after the last
   logic call_seen_reg;
   logic mon_reg; // Call-wide window flag
   logic lead_done_reg;
   logic [CW-1:0] lead_reg;
   logic [CW-1:0] hang_reg;
   wire call_rise = call_active && !call_seen_reg;
   wire lead_end = mon_reg && !lead_done_reg &&
                   (lead_reg >= CW'(LEAD_CYC) - 1'b1);
   // Hang restarts on every burst so it times from the last one
   wire hang_busy = (hang_reg != '0);
   wire mon_drop = mon_reg && lead_done_reg && !call_active &&
                   !tx_burst && !hang_busy;
   wire [CW-1:0] lead_next = (!mon_reg || lead_done_reg) ? '0
                                                         : lead_reg + 1'b1;
   wire [CW-1:0] hang_next = tx_burst ? CW'(HANG_CYC)
                             : hang_busy ? hang_reg - 1'b1 : '0;
   wire mon_next = call_rise ? 1'b1 : (mon_drop ? 1'b0 : mon_reg);
   wire lead_done_next = call_rise ? 1'b0
                         : (lead_end ? 1'b1 : lead_done_reg);

   // Monitor level for the selected mode
   wire mon_level = (mon_mode == gpio_pkg::MON_BURST) ? tx_burst
                                                       : mon_reg;

   // Inhibit pad held low by the application stops the radio
   wire inhibit_now = inhibit_sel && !pad_in[`INHIBIT_PAD];
   wire inhibit_seen_next = inhibit_now;
   logic inhibit_seen_reg;
   // In call mode bursts wait for the monitor lead-in to elapse
   wire lead_ok = (mon_mode == gpio_pkg::MON_BURST) || lead_done_reg;
   wire tx_permit_next = !inhibit_now && lead_ok;

   ////////////////////////////////////////////////////////////////////////
   // Alarm latch: set wins over a clear written in the same cycle
   logic alarm_reg;
   wire alarm_next = alarm_fire ? 1'b1
                     : (wr_alarm_clr ? 1'b0 : alarm_reg);

   ////////////////////////////////////////////////////////////////////////
   // Buzzer square wave
   logic tone_wave;
   tone_gen #(
      .DIV_W(16)
   ) u_tone (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(tone_sel),
      .half_period(tone_reg),
      .wave(tone_wave)
   );

   ////////////////////////////////////////////////////////////////////////
   // Converter: 10-bit code over 0..1300 mV, scaled by 1300/1024
   wire [20:0] adc_prod = 21'(adc_code) * 21'(`ADC_FULL_MV);
   wire [10:0] adc_mv_next = wr_adc_cmd ? adc_prod[20:10]
                                        : adc_mv_reg;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt events and sticky status
   wire [`IRQ_BITS-1:0] irq_event;
   assign irq_event[`IRQ_ALARM] = alarm_fire && !alarm_reg;
   assign irq_event[`IRQ_ADC] = wr_adc_cmd;
   assign irq_event[`IRQ_INHIBIT] = inhibit_now && !inhibit_seen_reg;
   assign irq_event[`IRQ_MONITOR] = call_rise;
   // An event in the clearing cycle survives the clear
   wire [`IRQ_BITS-1:0] irq_clr = wr_irq_clr ? wdata[`IRQ_BITS-1:0] : '0;
   wire [`IRQ_BITS-1:0] irq_stat_next = irq_event |
                                        (irq_stat_reg & ~irq_clr);
   wire irq_next = |(irq_stat_next & irq_en_reg);

   ////////////////////////////////////////////////////////////////////////
   // Pad multiplexing, one slice per pad
   logic [NUM_PADS-1:0] out_next;
   logic [NUM_PADS-1:0] oe_next;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PADS; gi++) begin : g_pad
         wire [1:0] fsel = func_reg[2*gi +: 2];
         wire is_out = (fsel == 2'(gpio_pkg::PAD_OUTPUT));
         wire is_alt = (fsel == 2'(gpio_pkg::PAD_ALTERNATE));
         // Alternate level of this pad; pads without one act as plain
         wire alt_level =
            (gi == `STATUS_PAD) ? !lamp_on :
            (gi == `MONITOR_PAD) ? mon_level :
            (gi == `ALARM_PAD) ? alarm_reg :
            (gi == `TONE_PAD) ? tone_wave :
            drive_reg[gi];
         // The inhibit pad stays an input when its function is chosen
         wire alt_drives = is_alt && (gi != `INHIBIT_PAD);
         // Push-pull: enable high drives both levels, no pull-up needed
         assign oe_next[gi] = is_out || alt_drives;
         assign out_next[gi] = alt_drives ? alt_level
                               : drive_reg[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped offsets read zero
   wire [31:0] rd_mux =
      (addr == `ADDR_CTRL) ? 32'(ctrl_reg) :
      (addr == `ADDR_FUNC) ? 32'(func_reg) :
      (addr == `ADDR_DRIVE) ? 32'(drive_reg) :
      (addr == `ADDR_PULL) ? 32'(pull_reg) :
      (addr == `ADDR_PADIN) ? 32'(pad_in) :
      (addr == `ADDR_TONE) ? 32'(tone_reg) :
      (addr == `ADDR_ADC_MV) ? 32'(adc_mv_reg) :
      (addr == `ADDR_IRQ_STAT) ? 32'(irq_stat_reg) :
      (addr == `ADDR_IRQ_EN) ? 32'(irq_en_reg) :
      32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // Software registers; pads come up as inputs with pull-down
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= 3'h0;
         func_reg <= (2*NUM_PADS)'(`FUNC_RST);
         drive_reg <= NUM_PADS'(`DRIVE_RST);
         pull_reg <= NUM_PADS'(`PULL_RST);
         tone_reg <= `TONE_RST;
         irq_en_reg <= '0;
      end else begin
         if (wr_ctrl) ctrl_reg <= wdata[2:0];
         if (wr_func) func_reg <= wdata[2*NUM_PADS-1:0];
         if (wr_drive) drive_reg <= wdata[NUM_PADS-1:0];
         if (wr_pull) pull_reg <= wdata[NUM_PADS-1:0];
         if (wr_tone) tone_reg <= wdata[15:0];
         if (wr_irq_en) irq_en_reg <= wdata[`IRQ_BITS-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lamp and monitor timers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         blink_reg <= '0;
         state_seen_reg <= 2'h0;
         call_seen_reg <= 1'b0;
         mon_reg <= 1'b0;
         // No call is open yet, so nothing holds the radio back
         lead_done_reg <= 1'b1;
         lead_reg <= '0;
         hang_reg <= '0;
         inhibit_seen_reg <= 1'b0;
      end else begin
         blink_reg <= blink_next;
         state_seen_reg <= ctrl_reg[1:0];
         call_seen_reg <= call_active;
         mon_reg <= mon_next;
         lead_done_reg <= lead_done_next;
         lead_reg <= lead_next;
         hang_reg <= hang_next;
         inhibit_seen_reg <= inhibit_seen_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alarm, converter and interrupt state
   // Alarm resets high so the alarm pad, once its function is chosen, stays high until a clear command
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         alarm_reg <= 1'b1;
         adc_mv_reg <= 11'h000;
         irq_stat_reg <= '0;
      end else begin
         alarm_reg <= alarm_next;
         adc_mv_reg <= adc_mv_next;
         irq_stat_reg <= irq_stat_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output flops
   // The alarm pad alone is driven high in reset, an exception to inputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pad_out <= NUM_PADS'(1) << `ALARM_PAD;
         pad_oe <= NUM_PADS'(1) << `ALARM_PAD;
         // The alarm pad is driven in reset, so its pull-down stays off
         pad_pd <= NUM_PADS'(`PULL_RST) &
                   ~(NUM_PADS'(1) << `ALARM_PAD);
         rdata <= 32'h00000000;
         tx_permit <= 1'b1;
         irq <= 1'b0;
      end else begin
         pad_out <= out_next;
         pad_oe <= oe_next;
         pad_pd <= pull_reg & ~oe_next;
         rdata <= rd ? rd_mux : 32'h00000000;
         tx_permit <= tx_permit_next;
         irq <= irq_next;
      end
   end

endmodule : gpio_indicator

// ### gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the plain register port
`define ADDR_CTRL 8'h00
`define ADDR_FUNC 8'h04
`define ADDR_DRIVE 8'h08
`define ADDR_PULL 8'h0C
`define ADDR_PADIN 8'h10
`define ADDR_ALARM_CLR 8'h14
`define ADDR_TONE 8'h18
`define ADDR_ADC_CMD 8'h1C
`define ADDR_ADC_MV 8'h20
`define ADDR_IRQ_STAT 8'h24
`define ADDR_IRQ_CLR 8'h28
`define ADDR_IRQ_EN 8'h2C

////////////////////////////////////////////////////////////////////////////
// Control register fields
`define CTRL_STATE_LSB 0
`define CTRL_MODE_BIT 2

// Interrupt status bit positions
`define IRQ_ALARM 0
`define IRQ_ADC 1
`define IRQ_INHIBIT 2
`define IRQ_MONITOR 3
`define IRQ_BITS 4

////////////////////////////////////////////////////////////////////////////
// Reset values
`define FUNC_RST 32'h00000000
`define PULL_RST 32'hFFFFFFFF
`define DRIVE_RST 32'h00000000
`define TONE_RST 16'h0000

////////////////////////////////////////////////////////////////////////////
// Pads that carry an alternate function
`define STATUS_PAD 0
`define INHIBIT_PAD 3
`define MONITOR_PAD 4
`define ALARM_PAD 5
`define TONE_PAD 6

////////////////////////////////////////////////////////////////////////////
// Clock rate and times, in their own units
`define CLK_KHZ 20000
`define FAST_PERIOD_MS 1000
`define FAST_ON_MS 500
`define SLOW_PERIOD_MS 3000
`define SLOW_ON_MS 300
`define LEAD_MS 300
`define HANG_MS 500

// Converter span and width
`define ADC_FULL_MV 1300
`define ADC_BITS 10

`endif

// ### gpio_pkg.sv
package gpio_pkg;

   // Network and call condition shown on the lamp
   typedef enum logic [1:0] {
      NET_OFF,
      NET_SEARCH,
      NET_REGISTERED,
      NET_CALL
   } net_state_t;

   // Function of one pad
   typedef enum logic [1:0] {
      PAD_INPUT,
      PAD_OUTPUT,
      PAD_ALTERNATE,
      PAD_SPARE
   } pad_func_t;

   // Transmit-activity monitor behaviour
   typedef enum logic {
      MON_CALL_WIDE,
      MON_BURST
   } mon_mode_t;

endpackage : gpio_pkg

// ### tone_gen.sv
`timescale 1ns/1ps

// Square-wave source for the buzzer driver
module tone_gen #(
   parameter int DIV_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [DIV_W-1:0] half_period,
   output logic wave
);

   // Cycles spent in the current half wave
   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] cnt_next;
   logic wave_next;
   logic running;
   logic flip;

   // A zero divisor means silence, so a stopped tone rests low
   assign running = enable && (half_period != '0);
   assign flip = running && (cnt_reg >= half_period - 1'b1);
   assign cnt_next = (!running || flip) ? '0 : cnt_reg + 1'b1;
   assign wave_next = running ? (wave ^ flip) : 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Half-period counter and output flop
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         wave <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         wave <= wave_next;
      end
   end

endmodule : tone_gen

// ### gpio_indicator_monitor.sv
`timescale 1ns/1ps
`include "gpio_map.svh"

// Port-level watcher for the pad block
module gpio_indicator_monitor #(
   parameter int NUM_PADS = 10
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [NUM_PADS-1:0] pad_in,
   input wire logic [NUM_PADS-1:0] pad_out,
   input wire logic [NUM_PADS-1:0] pad_oe,
   input wire logic [NUM_PADS-1:0] pad_pd,
   input wire logic call_active,
   input wire logic tx_burst,
   input wire logic alarm_fire,
   input wire logic tx_permit,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Reset itself is the cause here, so this one is never disabled
   AST_ALARM_IN_RESET: assert property (disable iff (1'h0)
      rst |-> pad_out[`ALARM_PAD] && pad_oe[`ALARM_PAD])
      else $error("alarm pad not driven high in reset");
   AST_PUSH_PULL: assert property ((pad_oe & pad_pd) == '0)
      else $error("pull-down left on a driven pad");
   AST_READ_IDLE: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data outside the read answer cycle");
   AST_WO_READ: assert property (rd && (addr == `ADDR_ALARM_CLR ||
      addr == `ADDR_ADC_CMD || addr == `ADDR_IRQ_CLR) |=> rdata == '0)
      else $error("write-only place reads nonzero");
   // Permit may only drop for a low inhibit pad or a call lead-in
   AST_INHIBIT: assert property ($fell(tx_permit) |->
      !$past(pad_in[`INHIBIT_PAD]) || $past(call_active))
      else $error("transmit permit dropped with no cause");
   AST_MON_CAUSE: assert property ($rose(pad_out[`MONITOR_PAD]) |->
      $past(call_active, 2) || $past(tx_burst) || $past(tx_burst, 2) ||
      $past(wr, 2))
      else $error("monitor pad rose with no transmit cause");
   AST_ALARM_RISE: assert property ($rose(pad_out[`ALARM_PAD]) |->
      $past(alarm_fire, 2) || $past(wr, 2))
      else $error("alarm pad rose with no alarm");
   AST_ALARM_HOLD: assert property ($fell(pad_out[`ALARM_PAD]) |->
      $past(wr, 2) || $past(rst, 2))
      else $error("alarm pad fell without a clearing write");

   // Main scenarios reached
   cover property ($rose(pad_out[`MONITOR_PAD]));
   cover property ($fell(tx_permit));
   cover property ($rose(irq));
   cover property (rd ##1 rdata != '0);
endmodule : gpio_indicator_monitor

bind gpio_indicator gpio_indicator_monitor #(.NUM_PADS(NUM_PADS)) mon (
   .ref_clk, .rst, .addr, .wr, .rd, .rdata, .pad_in, .pad_out, .pad_oe,
   .pad_pd, .call_active, .tx_burst, .alarm_fire, .tx_permit, .irq);

// ### pad_world.sv
`timescale 1ns/1ps

// Board around the pads: resistors, application drivers, lamp transistor
module pad_world #(
   parameter int NUM_PADS = 10
) (
   input wire logic [NUM_PADS-1:0] pad_out,
   input wire logic [NUM_PADS-1:0] pad_oe,
   input wire logic [NUM_PADS-1:0] pad_pd,
   input wire logic [NUM_PADS-1:0] app_en,
   input wire logic [NUM_PADS-1:0] app_level,
   output logic [NUM_PADS-1:0] pad_in,
   output logic lamp_lit
);
   // Inhibit pad carries a board pull-up stronger than the device pull-down
   localparam int INHIBIT = 3;

   // Wire level from every party; a floating pad other than the inhibit pad shows the inverse value unless its pull-down holds it low
   always_comb begin
      for (int i = 0; i < NUM_PADS; i++) begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (app_en[i])
            pad_in[i] = app_level[i];
         else if (i == INHIBIT)
            pad_in[i] = 1'h1;
         else
            pad_in[i] = pad_pd[i] ? 1'h0 : ~pad_out[i];
      end
   end

   // Transistor inverts the pin: lamp lit while the pin is low
   assign lamp_lit = pad_oe[0] & ~pad_out[0];
endmodule : pad_world

// ### testbench.sv
`timescale 1ns/1ps
`include "gpio_map.svh"

module testbench;
   // Short counts so every pattern fits in a brief run
   localparam int NP = 10;
   localparam int FP = 20;
   localparam int FO = 10;
   localparam int SP = 30;
   localparam int SO = 3;
   localparam int LD = 6;
   localparam int HG = 10;
   logic ref_clk = 1'h0;
   logic rst = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [31:0] rdata;
   logic [NP-1:0] pad_in, pad_out, pad_oe, pad_pd;
   logic [NP-1:0] app_en = '0;
   logic [NP-1:0] app_level = '0;
   logic call_active = 1'h0;
   logic tx_burst = 1'h0;
   logic alarm_fire = 1'h0;
   logic [9:0] adc_code = 10'h000;
   logic tx_permit, irq, lamp_lit;
   logic [9:0] codes [4] = '{10'h000, 10'h0C8, 10'h200, 10'h3FF};
   int mismatches = 0;
   int num_checks = 0;
   int n;

   gpio_indicator #(.NUM_PADS(NP), .FAST_PERIOD_CYC(FP), .FAST_ON_CYC(FO),
      .SLOW_PERIOD_CYC(SP), .SLOW_ON_CYC(SO), .LEAD_CYC(LD),
      .HANG_CYC(HG)) dut (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .pad_in, .pad_out, .pad_oe, .pad_pd, .call_active, .tx_burst,
      .alarm_fire, .adc_code, .tx_permit, .irq);
   pad_world #(.NUM_PADS(NP)) world (.pad_out, .pad_oe, .pad_pd, .app_en,
      .app_level, .pad_in, .lamp_lit);

   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One-cycle strobes, launched just after a rising edge
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge ref_clk);
      wr <= 1'h0;
   endtask : wreg

   // Read data stands only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge ref_clk);
      rd <= 1'h0;
      @(negedge ref_clk);
      chk(rdata, e);
   endtask : rreg

   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk);
   endtask : cyc

   // Lit cycles over one window; phase does not matter for a full period
   task automatic lit(input int len, output int c);
      c = 0;
      repeat (len) begin
         @(negedge ref_clk);
         if (lamp_lit === 1'h1)
            c++;
      end
   endtask : lit

   // Cycles between two edges of the tone pad, every wait bounded
   task automatic half_len(output int c);
      logic p;
      c = 0;
      p = pad_out[`TONE_PAD];
      while (pad_out[`TONE_PAD] === p && c < 40) begin
         @(negedge ref_clk);
         c++;
      end
      p = pad_out[`TONE_PAD];
      c = 0;
      while (pad_out[`TONE_PAD] === p && c < 40) begin
         @(negedge ref_clk);
         c++;
      end
   endtask : half_len

   ////////////////////////////////////////////////////////////////////////
   initial begin
      // Raised at time zero so the asynchronous reset sees a real edge
      rst <= 1'h1;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({pad_oe[5], pad_out[5], tx_permit}, 3'h7);
      @(posedge ref_clk);
      rst <= 1'h0;
      cyc(2);
      chk({pad_oe, pad_pd}, {NP'(0), {NP{1'h1}}});
      rreg(`ADDR_PULL, 32'h000003FF);
      rreg(`ADDR_FUNC, 32'h0);
      // Lamp, out pad 1, inhibit, monitor, alarm and tone pads selected
      wreg(`ADDR_FUNC, 32'h2A86);
      rreg(`ADDR_FUNC, 32'h2A86);
      wreg(`ADDR_DRIVE, 32'h2);
      cyc(2);
      chk({pad_oe[1], pad_out[1], pad_pd[1], pad_in[1]}, 4'hD);
      wreg(`ADDR_DRIVE, 32'h0);
      cyc(2);
      chk({pad_oe[1], pad_out[1], pad_pd[1], pad_in[1]}, 4'h8);
      // Lamp patterns per state
      wreg(`ADDR_CTRL, 32'h0);
      cyc(3);
      lit(FP, n);
      chk(n, 0);
      wreg(`ADDR_CTRL, 32'h3);
      cyc(3);
      lit(FP, n);
      chk(n, FP);
      wreg(`ADDR_CTRL, 32'h1);
      cyc(3);
      lit(2 * FP, n);
      chk(n, 2 * FO);
      wreg(`ADDR_CTRL, 32'h2);
      cyc(3);
      lit(SP, n);
      chk(n, SO);
      // Application pulls the inhibit pad low, then lets go
      @(posedge ref_clk);
      app_en[3] <= 1'h1;
      cyc(3);
      chk(tx_permit, 1'h0);
      @(posedge ref_clk);
      app_en[3] <= 1'h0;
      cyc(3);
      chk(tx_permit, 1'h1);
      // Call-wide monitor: lead-in, then hang after the last burst
      wreg(`ADDR_CTRL, 32'h3);
      @(posedge ref_clk);
      call_active <= 1'h1;
      cyc(3);
      chk({pad_out[4], tx_permit}, 2'h2);
      cyc(LD + 2);
      chk(tx_permit, 1'h1);
      @(posedge ref_clk);
      tx_burst <= 1'h1;
      cyc(2);
      @(posedge ref_clk);
      tx_burst <= 1'h0;
      call_active <= 1'h0;
      cyc(HG - 4);
      chk(pad_out[4], 1'h1);
      cyc(8);
      chk(pad_out[4], 1'h0);
      // Burst-following monitor tracks a lone burst
      wreg(`ADDR_CTRL, 32'h6);
      @(posedge ref_clk);
      tx_burst <= 1'h1;
      cyc(3);
      chk({pad_out[4], tx_permit}, 2'h3);
      @(posedge ref_clk);
      tx_burst <= 1'h0;
      cyc(3);
      chk(pad_out[4], 1'h0);
      // Alarm latch from reset, clear, fire, interrupt mask and clear
      chk(pad_out[5], 1'h1);
      wreg(`ADDR_ALARM_CLR, 32'h1);
      wreg(`ADDR_IRQ_CLR, 32'hF);
      wreg(`ADDR_IRQ_EN, 32'h1);
      cyc(2);
      chk({pad_out[5], irq}, 2'h0);
      @(posedge ref_clk);
      alarm_fire <= 1'h1;
      @(posedge ref_clk);
      alarm_fire <= 1'h0;
      cyc(HG);
      chk({pad_out[5], irq}, 2'h3);
      rreg(`ADDR_IRQ_STAT, 32'h1);
      wreg(`ADDR_IRQ_EN, 32'h0);
      cyc(2);
      chk(irq, 1'h0);
      wreg(`ADDR_IRQ_EN, 32'hF);
      wreg(`ADDR_IRQ_CLR, 32'h1);
      wreg(`ADDR_ALARM_CLR, 32'h1);
      cyc(2);
      chk({pad_out[5], irq}, 2'h0);
      // Converter codes across the span, read back in millivolts
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         adc_code <= codes[i];
         wreg(`ADDR_ADC_CMD, 32'h1);
         rreg(`ADDR_ADC_MV, (int'(codes[i]) * `ADC_FULL_MV) >> 10);
      end
      chk(irq, 1'h1);
      rreg(`ADDR_IRQ_STAT, 32'h2);
      rreg(`ADDR_ADC_CMD, 32'h0);
      rreg(8'h30, 32'h0);
      // Tone at a half period of four cycles, then silenced
      wreg(`ADDR_TONE, 32'h4);
      half_len(n);
      chk(n, 4);
      wreg(`ADDR_TONE, 32'h0);
      cyc(3);
      chk(pad_out[6], 1'h0);
      finish_test();
   end
endmodule : testbench
